// ==== clk_mode_pkg.sv ====
// Package of register map, field layout and divider constants for the channel clock mode block.
`default_nettype none
package clk_mode_pkg;
  // -------------------------------------------------------------------------
  // Register offsets (byte addresses on the APB bus).
  // -------------------------------------------------------------------------
  localparam logic [11:0] CONFIG_OFFSET = 12'h000;
  localparam logic [11:0] GLOBAL_OFFSET = 12'h004;
  localparam logic [11:0] BAUD_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00c;

  // -------------------------------------------------------------------------
  // Field positions and reset values.
  // -------------------------------------------------------------------------
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SSEL_BIT = 3;
  localparam int CFG_TOE_BIT = 4;
  localparam int CFG_BCR_BIT = 5;
  localparam int CFG_XTRANS_BIT = 6;
  localparam int GLB_OSCILLATOR_POWER_DOWN_BIT = 0;
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam logic GLOBAL_RESET = 1'b1;
  localparam logic [15:0] BAUD_RESET = 16'h0000;

  // -------------------------------------------------------------------------
  // Clock mode codes of the three-bit mode field.
  // -------------------------------------------------------------------------
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;

  // -------------------------------------------------------------------------
  // Divider and sampling constants.
  // -------------------------------------------------------------------------
  localparam logic [15:0] DIV16_LAST = 16'h000f;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
endpackage
`default_nettype wire

// ==== rate_divider.sv ====
// Tick divider: passes every (last+1)-th input tick and exposes its phase.
`default_nettype none
module rate_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [15:0] last,
  output logic tick_out,
  output logic [15:0] phase
);
  logic [15:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  // Clear parks the phase at zero so a newly selected divider starts aligned.
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (clear) begin
      cnt_d = 16'h0000;
    end else if (tick_in) begin
      if (cnt_q >= last) begin
        cnt_d = 16'h0000;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // Count and output tick registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
  assign phase = cnt_q;
endmodule
`default_nettype wire

// ==== majority_voter.sv ====
// Three-sample majority voter for oversampled asynchronous receive bits.
`default_nettype none
module majority_voter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_tick,
  input wire logic [3:0] phase,
  input wire logic data_in,
  output logic vote
);
  logic [1:0] samp_q, samp_d;
  logic vote_q, vote_d;

  // The third sample decides together with the two held ones.
  always_comb begin
    samp_d = samp_q;
    vote_d = vote_q;
    if (sample_tick) begin
      if (phase == clk_mode_pkg::SAMPLE_FIRST) begin
        samp_d[0] = data_in;
      end
      if (phase == clk_mode_pkg::SAMPLE_MID) begin
        samp_d[1] = data_in;
      end
      if (phase == clk_mode_pkg::SAMPLE_LAST) begin
        vote_d = (samp_q[0] & samp_q[1]) | (samp_q[0] & data_in) | (samp_q[1] & data_in);
      end
    end
  end

  // Sample and vote registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_q <= 2'h0;
      vote_q <= 1'b1;
    end else begin
      samp_q <= samp_d;
      vote_q <= vote_d;
    end
  end

  assign vote = vote_q;
endmodule
`default_nettype wire

// ==== channel_clock_select.sv ====
// Per-channel clock mode selection: domain ticks, strobes, gating, sync and transmit clock pin drive.
//
// What this block does
// [RULE1]: separate transmit and receive domain clocks
// [RULE2]: mode field plus source select choose mode
// [RULE3]: mode 6b: oscillator generator, tx gen/16, rx DPLL
// [RULE4]: DPLL receive clock is DPLL clock /16
// [RULE5]: mode 0: rx pin; tx pin or generator
// [RULE6]: mode 0b drives generated tx clock out
// [RULE7]: mode 1: rx pin clocks both, strobes qualify
// [RULE8]: transparent strobed mode: one strobe per byte
// [RULE9]: async divide-by-16 in modes 1, 3b, 7b; mode 0 divides receive only
// [RULE10]: rate select set: three-sample majority vote
// [RULE11]: rate select ignored in other modes
// [RULE12]: software powers oscillator for modes 0b,6,7
// [RULE13]: oscillator shared, generator and DPLL per channel
// [RULE14]: crystal input accepts an external clock
// [RULE15]: tx pin shows tx clock or slot signal
// [RULE16]: strobes, gates and sync inputs per mode
// [RULE17]: modes 2,3,6,7 generator, receive, transmit sources
// [RULE18]: mode 5a common clock; 5b separate clocks
// [RULE19]: generator feeds DPLL at sixteen times rate
// [RULE20]: mode 4 gates each clock per bit
// [RULE21]: mode 5a tx pin low in slot
`default_nettype none
module channel_clock_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic receive_clock_pin,
  input wire logic tx_clock_pin_in,
  input wire logic crystal_in_pin,
  input wire logic carrier_detect_pin,
  input wire logic receive_gate_pin,
  input wire logic transmit_gate_pin,
  input wire logic frame_sync_pin,
  input wire logic tx_octet_sync_pin,
  input wire logic rx_octet_sync_pin,
  input wire logic rx_data_pin,
  input wire logic rx_slot_active,
  input wire logic tx_slot_active,
  output logic tx_clock_pin_out,
  output logic tx_clock_pin_oe,
  output logic rx_domain_clock,
  output logic tx_domain_clock,
  output logic rx_bit,
  output logic rx_sync,
  output logic tx_sync
);
  // ---------------------------------------------------------------------------
  // Register file.
  // ---------------------------------------------------------------------------
  logic [6:0] cfg_q, cfg_d;
  logic oscillator_power_down_q, oscillator_power_down_d;
  logic [15:0] baud_q, baud_d;
  logic [31:0] prdata_q, prdata_d;
  logic [31:0] status;
  logic setup, access, mapped;
  logic [2:0] clock_mode_field;
  logic source_sel, transmit_output_enable, bit_clock_rate_sel, ext_transparent;

  assign clock_mode_field = cfg_q[clk_mode_pkg::CFG_MODE_LSB +: 3]; // [RULE2]
  assign source_sel = cfg_q[clk_mode_pkg::CFG_SSEL_BIT]; // [RULE2]
  assign transmit_output_enable = cfg_q[clk_mode_pkg::CFG_TOE_BIT];
  assign bit_clock_rate_sel = cfg_q[clk_mode_pkg::CFG_BCR_BIT];
  assign ext_transparent = cfg_q[clk_mode_pkg::CFG_XTRANS_BIT];

  // APB decode; the slave never waits, so the access phase always completes.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == clk_mode_pkg::CONFIG_OFFSET) | (paddr == clk_mode_pkg::GLOBAL_OFFSET) |
                  (paddr == clk_mode_pkg::BAUD_OFFSET) | (paddr == clk_mode_pkg::STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_q;

  // Writes land at the completing access edge; read data is captured in setup.
  always_comb begin
    cfg_d = cfg_q;
    oscillator_power_down_d = oscillator_power_down_q;
    baud_d = baud_q;
    prdata_d = prdata_q;
    if (access & pwrite) begin
      case (paddr)
        clk_mode_pkg::CONFIG_OFFSET: begin
          cfg_d = pwdata[6:0];
        end
        clk_mode_pkg::GLOBAL_OFFSET: begin
          oscillator_power_down_d = pwdata[clk_mode_pkg::GLB_OSCILLATOR_POWER_DOWN_BIT];
        end
        clk_mode_pkg::BAUD_OFFSET: begin
          baud_d = pwdata[15:0];
        end
        default: begin
          cfg_d = cfg_q;
        end
      endcase
    end
    if (setup) begin
      case (paddr)
        clk_mode_pkg::CONFIG_OFFSET: prdata_d = {25'h000_0000, cfg_q};
        clk_mode_pkg::GLOBAL_OFFSET: prdata_d = {31'h0000_0000, oscillator_power_down_q};
        clk_mode_pkg::BAUD_OFFSET: prdata_d = {16'h0000, baud_q};
        clk_mode_pkg::STATUS_OFFSET: prdata_d = status;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register file storage; the oscillator starts powered down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= clk_mode_pkg::CONFIG_RESET;
      oscillator_power_down_q <= clk_mode_pkg::GLOBAL_RESET;
      baud_q <= clk_mode_pkg::BAUD_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      oscillator_power_down_q <= oscillator_power_down_d;
      baud_q <= baud_d;
      prdata_q <= prdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin edge detection.
  // ---------------------------------------------------------------------------
  logic [6:0] pins, pins_q, rise;
  logic rxc_rise, txc_rise, xtal_rise, cd_rise, fsc_rise, ost_rise, osr_rise;

  assign pins = {rx_octet_sync_pin, tx_octet_sync_pin, frame_sync_pin, carrier_detect_pin,
                 crystal_in_pin, tx_clock_pin_in, receive_clock_pin};
  assign rise = pins & ~pins_q;
  assign {osr_rise, ost_rise, fsc_rise, cd_rise, xtal_rise, txc_rise, rxc_rise} = rise;

  // Pins are synchronous to pclk, so no extra stage is needed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 7'h00;
    end else begin
      pins_q <= pins;
    end
  end

  // ---------------------------------------------------------------------------
  // Oscillator, baud rate generator and DPLL.
  // ---------------------------------------------------------------------------
  logic osc_tick, brg_in, brg_tick, dpll_tick;
  logic osc_mode, pinfed_mode;

  // The crystal input alone may carry an external clock; a powered-down oscillator gives none.
  assign osc_tick = xtal_rise & ~oscillator_power_down_q; // [RULE14] [RULE12]
  assign osc_mode = ((clock_mode_field == clk_mode_pkg::MODE_0) & source_sel) |
                    (clock_mode_field == clk_mode_pkg::MODE_6) | (clock_mode_field == clk_mode_pkg::MODE_7);
  assign pinfed_mode = (clock_mode_field == clk_mode_pkg::MODE_2) | (clock_mode_field == clk_mode_pkg::MODE_3);
  // Oscillator or receive pin feeds this channel's own generator.
  assign brg_in = (osc_mode & osc_tick) | (pinfed_mode & rxc_rise); // [RULE17] [RULE13] [RULE3]

  // Generator divides by baud register plus one; it is private to this channel.
  rate_divider u_brg (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(brg_in),
    .clear(1'b0),
    .last(baud_q),
    .tick_out(brg_tick),
    .phase()
  ); // [RULE13]

  // With no phase tracking the DPLL output is the generator reference over sixteen,
  // which is also the generator/16 transmit source.
  rate_divider u_dpll (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(brg_tick),
    .clear(1'b0),
    .last(clk_mode_pkg::DIV16_LAST),
    .tick_out(dpll_tick),
    .phase()
  ); // [RULE19] [RULE4]

  // ---------------------------------------------------------------------------
  // Source selection per mode.
  // ---------------------------------------------------------------------------
  logic rx_base, tx_base, strobe_mode, bcr_rx, bcr_tx;

  // Pick raw domain ticks for each mode and sub-mode.
  always_comb begin
    rx_base = 1'b0;
    tx_base = 1'b0;
    strobe_mode = 1'b0;
    case (clock_mode_field)
      clk_mode_pkg::MODE_0: begin
        rx_base = rxc_rise; // [RULE5]
        tx_base = source_sel ? brg_tick : txc_rise; // [RULE5]
      end
      clk_mode_pkg::MODE_1: begin
        strobe_mode = 1'b1; // [RULE7]
      end
      clk_mode_pkg::MODE_2, clk_mode_pkg::MODE_6: begin
        rx_base = dpll_tick; // [RULE3] [RULE17]
        tx_base = source_sel ? dpll_tick : txc_rise; // [RULE3] [RULE17]
      end
      clk_mode_pkg::MODE_3, clk_mode_pkg::MODE_7: begin
        rx_base = source_sel ? brg_tick : dpll_tick; // [RULE17]
        tx_base = source_sel ? brg_tick : dpll_tick; // [RULE17]
      end
      clk_mode_pkg::MODE_4: begin
        rx_base = rxc_rise & ~receive_gate_pin; // [RULE20] [RULE16]
        tx_base = txc_rise & ~transmit_gate_pin; // [RULE20] [RULE16]
      end
      clk_mode_pkg::MODE_5: begin
        rx_base = rxc_rise & rx_slot_active; // [RULE18] [RULE16]
        tx_base = (source_sel ? txc_rise : rxc_rise) & tx_slot_active; // [RULE18]
      end
      default: begin
        rx_base = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Strobed clocking in mode 1.
  // ---------------------------------------------------------------------------
  logic [3:0] rx_left_q, rx_left_d, tx_left_q, tx_left_d;
  logic rx_strobed, tx_strobed, rx_src, tx_src;

  // Per-bit mode passes every receive clock edge while its strobe is high; transparent mode arms a whole byte per strobe edge.
  always_comb begin
    rx_left_d = rx_left_q;
    tx_left_d = tx_left_q;
    rx_strobed = 1'b0;
    tx_strobed = 1'b0;
    if (!strobe_mode) begin
      rx_left_d = 4'h0;
      tx_left_d = 4'h0;
    end else if (!ext_transparent) begin
      rx_strobed = rxc_rise & carrier_detect_pin; // [RULE7] [RULE16]
      tx_strobed = rxc_rise & tx_clock_pin_in; // [RULE7] [RULE16]
    end else begin
      if (rxc_rise && rx_left_q != 4'h0) begin
        rx_strobed = 1'b1;
        rx_left_d = rx_left_q - 4'h1;
      end else if (cd_rise && rx_left_q == 4'h0) begin
        rx_left_d = clk_mode_pkg::BYTE_BITS; // [RULE8]
      end
      if (rxc_rise && tx_left_q != 4'h0) begin
        tx_strobed = 1'b1;
        tx_left_d = tx_left_q - 4'h1;
      end else if (txc_rise && tx_left_q == 4'h0) begin
        tx_left_d = clk_mode_pkg::BYTE_BITS; // [RULE8]
      end
    end
  end

  // Byte-alignment bit counters.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_left_q <= 4'h0;
      tx_left_q <= 4'h0;
    end else begin
      rx_left_q <= rx_left_d;
      tx_left_q <= tx_left_d;
    end
  end

  assign rx_src = rx_base | rx_strobed;
  assign tx_src = tx_base | tx_strobed;

  // ---------------------------------------------------------------------------
  // Bit clock rate division and majority sampling.
  // ---------------------------------------------------------------------------
  logic rx_div_tick, tx_div_tick, vote;
  logic [15:0] rx_phase;

  // Division applies only where the rate select is honoured; elsewhere it is ignored.
  assign bcr_rx = bit_clock_rate_sel & ((clock_mode_field == clk_mode_pkg::MODE_0) |
                  (clock_mode_field == clk_mode_pkg::MODE_1) |
                  (((clock_mode_field == clk_mode_pkg::MODE_3) | (clock_mode_field == clk_mode_pkg::MODE_7)) &
                   source_sel)); // [RULE9] [RULE11]
  assign bcr_tx = bit_clock_rate_sel & ((clock_mode_field == clk_mode_pkg::MODE_1) |
                  (((clock_mode_field == clk_mode_pkg::MODE_3) | (clock_mode_field == clk_mode_pkg::MODE_7)) &
                   source_sel)); // [RULE9] [RULE11]

  // Receive divide-by-16; its phase also steers the voter.
  rate_divider u_rx_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(rx_src),
    .clear(~bcr_rx),
    .last(clk_mode_pkg::DIV16_LAST),
    .tick_out(rx_div_tick),
    .phase(rx_phase)
  ); // [RULE9]

  // Transmit divide-by-16.
  rate_divider u_tx_div (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(tx_src),
    .clear(~bcr_tx),
    .last(clk_mode_pkg::DIV16_LAST),
    .tick_out(tx_div_tick),
    .phase()
  ); // [RULE9]

  // Three samples around mid-bit decide the received value.
  majority_voter u_vote (
    .pclk(pclk),
    .presetn(presetn),
    .sample_tick(rx_src & bcr_rx),
    .phase(rx_phase[3:0]),
    .data_in(rx_data_pin),
    .vote(vote)
  ); // [RULE10]

  // ---------------------------------------------------------------------------
  // Domain ticks, receive bit, sync and transmit pin.
  // ---------------------------------------------------------------------------
  logic rx_tick_q, rx_tick_d, tx_tick_q, tx_tick_d, rx_bit_q, rx_bit_d;
  logic rx_sync_q, rx_sync_d, tx_sync_q, tx_sync_d, tx_level_q, tx_level_d;
  logic pin_q, pin_d, oe_q, oe_d, oe_mode;
  logic [7:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;

  // Output enable is allowed only where the transmit clock is generated internally, or in 5a.
  assign oe_mode = ((clock_mode_field == clk_mode_pkg::MODE_0) & source_sel) |
                   (((clock_mode_field == clk_mode_pkg::MODE_2) | (clock_mode_field == clk_mode_pkg::MODE_6)) &
                    source_sel) |
                   (clock_mode_field == clk_mode_pkg::MODE_3) | (clock_mode_field == clk_mode_pkg::MODE_7) |
                   ((clock_mode_field == clk_mode_pkg::MODE_5) & ~source_sel);

  // Next values of the independent receive and transmit domain ticks and pin drive.
  always_comb begin
    rx_tick_d = bcr_rx ? rx_div_tick : rx_src; // [RULE1]
    tx_tick_d = bcr_tx ? tx_div_tick : tx_src; // [RULE1]
    rx_bit_d = rx_bit_q;
    if (bcr_rx) begin
      rx_bit_d = vote; // [RULE10]
    end else if (rx_src) begin
      rx_bit_d = rx_data_pin;
    end
    rx_sync_d = 1'b0;
    tx_sync_d = 1'b0;
    if (clock_mode_field == clk_mode_pkg::MODE_5) begin
      rx_sync_d = source_sel ? osr_rise : fsc_rise; // [RULE16] [RULE18]
      tx_sync_d = source_sel ? ost_rise : fsc_rise; // [RULE16] [RULE18]
    end
    tx_level_d = tx_tick_q ? ~tx_level_q : tx_level_q;
    oe_d = transmit_output_enable & oe_mode; // [RULE6] [RULE15]
    pin_d = tx_level_q; // [RULE15]
    if ((clock_mode_field == clk_mode_pkg::MODE_5) && !source_sel) begin
      pin_d = ~tx_slot_active; // [RULE21]
    end
    rx_cnt_d = rx_tick_q ? rx_cnt_q + 8'h01 : rx_cnt_q;
    tx_cnt_d = tx_tick_q ? tx_cnt_q + 8'h01 : tx_cnt_q;
  end

  // Output and activity counter registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
      rx_bit_q <= 1'b1;
      rx_sync_q <= 1'b0;
      tx_sync_q <= 1'b0;
      tx_level_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      rx_cnt_q <= 8'h00;
      tx_cnt_q <= 8'h00;
    end else begin
      rx_tick_q <= rx_tick_d;
      tx_tick_q <= tx_tick_d;
      rx_bit_q <= rx_bit_d;
      rx_sync_q <= rx_sync_d;
      tx_sync_q <= tx_sync_d;
      tx_level_q <= tx_level_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      rx_cnt_q <= rx_cnt_d;
      tx_cnt_q <= tx_cnt_d;
    end
  end

  // Status shows pin drive and domain tick counts.
  assign status = {8'h00, tx_cnt_q, rx_cnt_q, 3'h0, bcr_tx, bcr_rx, rx_bit_q, pin_q, oe_q};
  assign rx_domain_clock = rx_tick_q;
  assign tx_domain_clock = tx_tick_q;
  assign rx_bit = rx_bit_q;
  assign rx_sync = rx_sync_q;
  assign tx_sync = tx_sync_q;
  assign tx_clock_pin_out = pin_q;
  assign tx_clock_pin_oe = oe_q;
endmodule
`default_nettype wire

// ==== channel_clock_select_props.sv ====
// Property checker for the channel clock selector.
`default_nettype none
module channel_clock_select_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic receive_clock_pin,
  input wire logic carrier_detect_pin,
  input wire logic receive_gate_pin,
  input wire logic tx_slot_active,
  input wire logic tx_clock_pin_out,
  input wire logic tx_clock_pin_oe,
  input wire logic rx_domain_clock,
  input wire logic rx_sync,
  input wire logic tx_sync
);
  logic [6:0] cfg_q, cfg_d;
  logic [1:0] age_q, age_d;
  logic hit, calm, oe_ok;
  // All checks but a_unmapped_refused wait until the last config write has settled in the design.
  assign hit = psel && penable && pwrite && paddr == 12'h000;
  assign calm = age_q == 2'h3;
  assign oe_ok = cfg_q[4] && (cfg_q[3] ? !(cfg_q[2:0] inside {3'h1, 3'h4, 3'h5}) : cfg_q[2:0] inside {3'h3, 3'h5, 3'h7});
  always_comb begin
    cfg_d = hit ? pwdata[6:0] : cfg_q;
    age_d = hit ? 2'h0 : age_q + {1'b0, !calm};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 7'h00;
      age_q <= 2'h0;
    end else begin
      cfg_q <= cfg_d;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_gate_held;
    receive_gate_pin [*4];
  endsequence
  // Windows allow for the edge detector and the tick register.
  a_unmapped_refused: assert property (
    psel && penable && (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  a_pin_edge_tick: assert property (
    calm && cfg_q[2:0] == 3'h0 && !cfg_q[5] && $rose(receive_clock_pin) |-> ##[1:3] rx_domain_clock)
    else $error("no receive tick after pin edge");
  a_gate_blocks: assert property (s_gate_held ##0 (calm && cfg_q[2:0] == 3'h4) |-> !rx_domain_clock)
    else $error("receive tick while gated");
  a_strobe_blocks: assert property (
    !carrier_detect_pin [*4] ##0 (calm && cfg_q[2:0] == 3'h1 && !cfg_q[6]) |-> !rx_domain_clock)
    else $error("receive tick without strobe");
  a_pin_idle_off: assert property (calm && !oe_ok |-> !tx_clock_pin_oe)
    else $error("pin driven in a mode without output");
  a_pin_drive_on: assert property (calm && oe_ok |-> tx_clock_pin_oe)
    else $error("transmit pin not driven");
  a_slot_low: assert property (
    calm && cfg_q[4:0] == 5'h15 && $rose(tx_slot_active) |-> ##[1:3] !tx_clock_pin_out)
    else $error("transmit pin not low in slot");
  a_sync_mode5: assert property (calm && cfg_q[2:0] != 3'h5 |-> !rx_sync && !tx_sync)
    else $error("sync pulse outside slot mode");
endmodule
bind channel_clock_select channel_clock_select_props channel_clock_select_props_i (.*);
`default_nettype wire

// ==== line_clock_source.sv ====
// Far-side line clock: pulse bursts, low between them.
`default_nettype none
module line_clock_source (
  input wire logic pclk,
  input wire logic start,
  input wire logic [7:0] pulses,
  output logic busy,
  output logic line_clk
);
  logic [8:0] left_q = 9'h000;
  logic [1:0] cnt_q = 2'h0;
  // Three pclk per half period; one wave feeds line, strobe and crystal pins.
  always_ff @(posedge pclk) begin
    if (start) begin
      left_q <= {pulses, 1'b0};
      cnt_q <= 2'h0;
    end else if (left_q != 9'h000) begin
      cnt_q <= cnt_q == 2'h2 ? 2'h0 : cnt_q + 2'h1;
      if (cnt_q == 2'h2) left_q <= left_q - 9'h001;
    end
  end
  // An even count ends each burst low.
  assign line_clk = left_q[0];
  assign busy = left_q != 9'h000;
endmodule
`default_nettype wire

// ==== test_channel_clock_select.sv ====
// Testbench for the channel clock selector.
`default_nettype none
module test_channel_clock_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, cd = 1'b0;
  logic rgate = 1'b0, tgate = 1'b0, fsync = 1'b0, rxd = 1'b1, slot = 1'b0;
  logic pready, pslverr, line_clk, busy, oe, pin_out, rx_tick, tx_tick, rx_bit;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0] pulses = 8'h00;
  int errors = 0, check_count = 0, rx_n = 0, tx_n = 0;
  always #4 pclk = ~pclk;
  // Counts domain ticks for judging each burst.
  always @(posedge pclk) begin
    if (rx_tick === 1'b1) rx_n++;
    if (tx_tick === 1'b1) tx_n++;
  end
  channel_clock_select channel_clock_select_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .receive_clock_pin(line_clk), .tx_clock_pin_in(line_clk), .crystal_in_pin(line_clk),
    .carrier_detect_pin(cd), .receive_gate_pin(rgate), .transmit_gate_pin(tgate), .frame_sync_pin(fsync),
    .tx_octet_sync_pin(1'b0), .rx_octet_sync_pin(1'b0), .rx_data_pin(rxd), .rx_slot_active(1'b0),
    .tx_slot_active(slot), .tx_clock_pin_out(pin_out), .tx_clock_pin_oe(oe), .rx_domain_clock(rx_tick),
    .tx_domain_clock(tx_tick), .rx_bit, .rx_sync(), .tx_sync()
  );
  line_clock_source line_clock_source_i (.pclk, .start(go), .pulses, .busy, .line_clk);
  task automatic summarize;
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpb(input string what, input logic exp, input logic got);
    cmp(what, 32'(exp), 32'(got));
  endtask
  // Request holds until pready is seen high; the wait is bounded.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    cmp(what, exp, r);
    cmpb(what, exp_err, e);
  endtask
  // One line burst; a negative transmit count skips that compare.
  task automatic burst(input string what, input logic [7:0] n, input int exp_rx, input int exp_tx);
    int r0 = rx_n, t0 = tx_n, i = 0;
    pulses <= n;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1 && i < 4000) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 4000) begin
      errors++;
      summarize();
    end
    repeat (40) @(posedge pclk);
    cmp(what, 32'(exp_rx), 32'(rx_n - r0));
    if (exp_tx >= 0) cmp(what, 32'(exp_tx), 32'(tx_n - t0));
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd("config reset", 12'h000, 32'h0000_0000, 1'b0);
    rd("global reset", 12'h004, 32'h0000_0001, 1'b0);
    rd("baud reset", 12'h008, 32'h0000_0000, 1'b0);
    wr(12'h010, 32'hffff_ffff);
    rd("unmapped", 12'h010, 32'h0000_0000, 1'b1);
    wr(12'h000, 32'hffff_ffff);
    rd("config fields", 12'h000, 32'h0000_007f, 1'b0);
    wr(12'h004, 32'h0000_0000);
    wr(12'h000, 32'h0000_000e);
    burst("mode 6b", 8'h20, 2, 2);
    wr(12'h000, 32'h0000_0023);
    burst("mode 3a", 8'h20, 2, 2);
    rxd <= 1'b0;
    wr(12'h000, 32'h0000_0020);
    burst("mode 0a divided", 8'h20, 2, 32);
    cmpb("voted bit", 1'b0, rx_bit);
    wr(12'h000, 32'h0000_0000);
    burst("mode 0a", 8'h08, 8, 8);
    wr(12'h008, 32'h0000_0001);
    wr(12'h000, 32'h0000_0018);
    burst("mode 0b", 8'h08, 8, 4);
    cmpb("0b pin enable", 1'b1, oe);
    cd <= 1'b1;
    wr(12'h000, 32'h0000_0001);
    burst("strobe on", 8'h08, 8, 8);
    cd <= 1'b0;
    burst("strobe off", 8'h08, 0, 8);
    wr(12'h000, 32'h0000_0041);
    cd <= 1'b1;
    repeat (2) @(posedge pclk);
    cd <= 1'b0;
    burst("byte strobe", 8'h10, 8, -1);
    rgate <= 1'b1;
    tgate <= 1'b1;
    wr(12'h000, 32'h0000_0004);
    burst("gated", 8'h08, 0, 0);
    rgate <= 1'b0;
    tgate <= 1'b0;
    burst("ungated", 8'h08, 8, 8);
    wr(12'h000, 32'h0000_0012);
    repeat (3) @(posedge pclk);
    cmpb("2a pin enable", 1'b0, oe);
    wr(12'h000, 32'h0000_0015);
    fsync <= 1'b1;
    repeat (4) @(posedge pclk);
    slot <= 1'b1;
    repeat (4) @(posedge pclk);
    cmpb("slot pin", 1'b0, pin_out);
    slot <= 1'b0;
    repeat (4) @(posedge pclk);
    cmpb("idle pin", 1'b1, pin_out);
    cmpb("5a pin enable", 1'b1, oe);
    rd("status", 12'h00c, {8'h00, 8'(tx_n), 8'(rx_n), 8'h03}, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
